/* include/video_front_end_map.vh */
// register map, field positions, reset values and axi responses of the video front end
`ifndef VIDEO_FRONT_END_MAP_VH
`define VIDEO_FRONT_END_MAP_VH

// register byte offsets
`define VIN_CTRL_OFS         4'h0
`define VIN_VWIN_OFS         4'h4
`define VIN_HWIN_OFS         4'h8
`define VIN_STAT_OFS         4'hc

// control register fields
`define VIN_CTRL_ENABLE      0
`define VIN_CTRL_EXT_FIELD   1
`define VIN_CTRL_HPOL        2
`define VIN_CTRL_VPOL        3
`define VIN_CTRL_TOP_FIELD   4
`define VIN_CTRL_QUAL_POL    5
`define VIN_CTRL_RESET       6'h30

// window registers: start in the low half, end in the high half
`define VIN_WIN_START_LSB    0
`define VIN_WIN_END_LSB      16
`define VIN_WIN_START_RESET  10'h000
`define VIN_WIN_END_RESET    10'h3ff

// status register fields
`define VIN_STAT_TOP         0
`define VIN_STAT_LINE_IN     1
`define VIN_STAT_LCNT_LSB    16

// axi responses
`define VIN_RESP_OKAY        2'h0
`define VIN_RESP_SLVERR      2'h2

`endif

/* logic/video_front_end.v */
// video front end: samples a YUV 4:2:2 pixel bus, derives field identity and crops
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "video_front_end_map.vh"

// Summary of operation
// - luma, chroma and both syncs are captured on every other rising edge of the fast clock.
// - the captured edge is the one where the qualifier equals the qualifier polarity setting.
// - counters and pixel capture advance only on rising edges of the double-rate clock; field_top_o is updated every cycle.
// - field identity comes from the field indicator pin when selected, else from sync timing.
// - with the pin as source, interpretation 1 means a high pin is top field, 0 means low is top.
// - inferred field samples hsync at the active vsync edge; 1 means high is top, 0 low is top.
// - lines are counted from the active vsync edge and sampling starts at the vertical start line.
// - sampling stops after the line whose count equals the vertical end value.
// - pixels are counted from the active hsync edge and the first taken is at horizontal start.
// - the last pixel taken in a line is at the horizontal end count.
// - horizontal polarity 1 counts from the falling hsync edge, otherwise from the rising edge.
// - vertical polarity 1 counts lines from the falling vsync edge, otherwise the rising edge.
// - counters and window values cover up to 1024 pixels per line and 1024 lines per frame.
module video_front_end #(
  parameter CNT_W = 10
) (
  // clock and reset
  input  wire              sys_clk_i,
  input  wire              arst_n_i,
  // video pins
  input  wire              double_rate_pixel_clock_i,
  input  wire              pixel_clock_qualifier_i,
  input  wire [7:0]        luma_bus_i,
  input  wire [7:0]        chroma_bus_i,
  input  wire              hsync_i,
  input  wire              vsync_i,
  input  wire              field_indicator_input_i,
  // cropped pixel stream
  output reg               pix_valid_o,
  output reg  [7:0]        pix_luma_o,
  output reg  [7:0]        pix_chroma_o,
  output reg               pix_top_field_o,
  output reg               field_top_o,
  // axi4-lite write
  input  wire [3:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read
  input  wire [3:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  localparam NPIN = 21;
  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  // the register layout assumes CNT_W of 10; wider counts would overlap fields

  // control state
  reg  [5:0]       ctrl;
  reg  [CNT_W-1:0] vertical_start;
  reg  [CNT_W-1:0] vertical_end;
  reg  [CNT_W-1:0] horizontal_start;
  reg  [CNT_W-1:0] horizontal_end;

  wire enable                   = ctrl[`VIN_CTRL_ENABLE];
  wire external_field_select    = ctrl[`VIN_CTRL_EXT_FIELD];
  wire horizontal_polarity      = ctrl[`VIN_CTRL_HPOL];
  wire vertical_polarity        = ctrl[`VIN_CTRL_VPOL];
  wire top_field_interpretation = ctrl[`VIN_CTRL_TOP_FIELD];
  wire qualifier_polarity       = ctrl[`VIN_CTRL_QUAL_POL];

  // two-stage synchronisers for every pin; all pins see equal delay so their
  // relative timing is kept
  wire [NPIN-1:0] pin_raw = {double_rate_pixel_clock_i, pixel_clock_qualifier_i, luma_bus_i,
                             chroma_bus_i, hsync_i, vsync_i, field_indicator_input_i};
  wire [NPIN-1:0] pin_sync;
  reg             clk2_prev;

  // one flip-flop pair per pin; nothing but the second stage reads the first
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin_sync
      reg stage1;
      reg stage2;
      always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= pin_raw[gi];
          stage2 <= stage1;
        end
      end
      assign pin_sync[gi] = stage2;
    end
  endgenerate

  // edge history of the fast clock, taken from the settled second stage
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk2_prev <= 1'b0;
    end else begin
      clk2_prev <= pin_sync[20];
    end
  end

  wire       clk2_s  = pin_sync[20];
  wire       qual_s  = pin_sync[19];
  wire [7:0] luma_s  = pin_sync[18:11];
  wire [7:0] chrom_s = pin_sync[10:3];
  wire       hs_s    = pin_sync[2];
  wire       vs_s    = pin_sync[1];
  wire       fld_s   = pin_sync[0];

  // rising edge of the double-rate clock, kept only when the qualifier
  // matches the programmed polarity
  wire clk2_rise = clk2_s & ~clk2_prev;
  wire pix_en    = clk2_rise & (qual_s == qualifier_polarity);

  // sync history at qualified edges
  reg              hs_prev;
  reg              vs_prev;
  reg  [CNT_W-1:0] hcnt;
  reg  [CNT_W-1:0] vcnt;
  reg              field_inferred;

  wire h_edge = horizontal_polarity ? (hs_prev & ~hs_s) : (~hs_prev & hs_s);
  wire v_edge = vertical_polarity ? (vs_prev & ~vs_s) : (~vs_prev & vs_s);

  // count of this sample; saturates rather than wrapping on overlong lines
  wire [CNT_W-1:0] next_hcnt = h_edge ? {CNT_W{1'b0}} :
                               (hcnt == CNT_MAX) ? hcnt : hcnt + 1'b1;
  wire [CNT_W-1:0] next_vcnt = v_edge ? {CNT_W{1'b0}} :
                               (h_edge && vcnt != CNT_MAX) ? vcnt + 1'b1 : vcnt;

  wire line_in  = (next_vcnt >= vertical_start) && (next_vcnt <= vertical_end);
  wire pixel_in = (next_hcnt >= horizontal_start) && (next_hcnt <= horizontal_end);

  // the pin path follows the pin at once; the inferred path only moves at vsync
  wire field_ext   = top_field_interpretation ? fld_s : ~fld_s;
  wire field_now   = external_field_select ? field_ext : field_inferred;

  // counters run while disabled too, so enabling mid-frame keeps line numbers right
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hs_prev        <= 1'b0;
      vs_prev        <= 1'b0;
      hcnt           <= {CNT_W{1'b0}};
      vcnt           <= {CNT_W{1'b0}};
      field_inferred <= 1'b1;
      field_top_o    <= 1'b1;
    end else begin
      field_top_o <= field_now;
      if (pix_en) begin
        hs_prev <= hs_s;
        vs_prev <= vs_s;
        hcnt    <= next_hcnt;
        vcnt    <= next_vcnt;
        if (v_edge) begin
          field_inferred <= top_field_interpretation ? hs_s : ~hs_s;
        end
      end
    end
  end

  // a sample is forwarded only inside both windows and while enabled
  wire take_pixel = pix_en && enable && line_in && pixel_in;

  // valid is a one-cycle pulse; data hold until the next forwarded pixel
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pix_valid_o     <= 1'b0;
      pix_luma_o      <= 8'h00;
      pix_chroma_o    <= 8'h00;
      pix_top_field_o <= 1'b1;
    end else begin
      pix_valid_o <= take_pixel;
      // samples outside either window are dropped here
      if (take_pixel) begin
        pix_luma_o      <= luma_s;
        pix_chroma_o    <= chrom_s;
        pix_top_field_o <= field_now;
      end
    end
  end

  // axi4-lite slave: address and data latched independently, write done
  // once both are held
  reg        aw_full;
  reg        w_full;
  reg  [3:0] aw_addr;
  reg [31:0] w_data;
  reg  [3:0] w_strb;

  assign s_axi_awready = ~aw_full;
  assign s_axi_wready  = ~w_full;
  assign s_axi_arready = ~s_axi_rvalid;

  wire do_write = aw_full & w_full & ~s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer      i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // read-back words; unused bits read zero
  wire [31:0] ctrl_word = {26'h0, ctrl};
  wire [31:0] vwin_word = {6'h0, vertical_end, 6'h0, vertical_start};
  wire [31:0] hwin_word = {6'h0, horizontal_end, 6'h0, horizontal_start};
  wire [31:0] stat_word = {6'h0, vcnt, 14'h0, line_in, field_now};
  // byte strobes merge over the current contents
  wire [31:0] ctrl_new  = merge(ctrl_word, w_data, w_strb);
  wire [31:0] vwin_new  = merge(vwin_word, w_data, w_strb);
  wire [31:0] hwin_new  = merge(hwin_word, w_data, w_strb);

  // write channels: address and data may be taken in either order
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `VIN_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status is read-only but still answers okay to a write
        case ({aw_addr[3:2], 2'b00})
          `VIN_CTRL_OFS, `VIN_VWIN_OFS, `VIN_HWIN_OFS, `VIN_STAT_OFS: begin
            s_axi_bresp <= `VIN_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `VIN_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // register file; updated in the cycle that raises the write response
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl             <= `VIN_CTRL_RESET;
      vertical_start   <= `VIN_WIN_START_RESET;
      vertical_end     <= `VIN_WIN_END_RESET;
      horizontal_start <= `VIN_WIN_START_RESET;
      horizontal_end   <= `VIN_WIN_END_RESET;
    end else begin
      if (do_write) begin
        case ({aw_addr[3:2], 2'b00})
          `VIN_CTRL_OFS: begin
            ctrl <= ctrl_new[5:0];
          end
          `VIN_VWIN_OFS: begin
            vertical_start <= vwin_new[`VIN_WIN_START_LSB +: CNT_W];
            vertical_end   <= vwin_new[`VIN_WIN_END_LSB +: CNT_W];
          end
          `VIN_HWIN_OFS: begin
            horizontal_start <= hwin_new[`VIN_WIN_START_LSB +: CNT_W];
            horizontal_end   <= hwin_new[`VIN_WIN_END_LSB +: CNT_W];
          end
          default: begin
            ctrl <= ctrl;
          end
        endcase
      end
    end
  end

  // read channel: one read at a time, a new address waits until rvalid drops;
  // status is a snapshot and may be a few cycles behind the pins
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `VIN_RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `VIN_RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'b00})
          `VIN_CTRL_OFS: begin
            s_axi_rdata <= ctrl_word;
          end
          `VIN_VWIN_OFS: begin
            s_axi_rdata <= vwin_word;
          end
          `VIN_HWIN_OFS: begin
            s_axi_rdata <= hwin_word;
          end
          `VIN_STAT_OFS: begin
            s_axi_rdata <= stat_word;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `VIN_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule // video_front_end

/* tb/video_front_end_props.sv */
// port assertions for the video front end
`timescale 1ns/10ps
module video_front_end_props #(parameter CNT_W = 10) (
  // clock and reset
  input wire        sys_clk_i,
  input wire        arst_n_i,
  // video pins
  input wire        double_rate_pixel_clock_i,
  input wire        vsync_i,
  input wire        field_indicator_input_i,
  // pixel stream
  input wire        pix_valid_o,
  input wire [7:0]  pix_luma_o,
  input wire        field_top_o,
  // register bus
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_bvalid,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  reg [3:0] since_rise;
  reg [3:0] since_evt;
  // ages saturate at 15 so they never wrap into a false match
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      since_rise <= 4'hf;
      since_evt  <= 4'hf;
    end else begin
      since_rise <= $rose(double_rate_pixel_clock_i) ? 4'h0 : since_rise + (since_rise != 4'hf);
      since_evt  <= ($changed(vsync_i) || $changed(field_indicator_input_i) ||
                     (s_axi_wvalid && s_axi_wready)) ? 4'h0 : since_evt + (since_evt != 4'hf);
    end
  end
  property p_pix_pulse; pix_valid_o |=> !pix_valid_o [*8]; endproperty
  a_pix_pulse: assert property (p_pix_pulse) else $error("pixels too close");
  property p_pix_edge; pix_valid_o |-> since_rise >= 4'h1 && since_rise <= 4'h7; endproperty
  a_pix_edge: assert property (p_pix_edge) else $error("pixel not after clock rise");
  property p_luma_move; $changed(pix_luma_o) |-> pix_valid_o; endproperty
  a_luma_move: assert property (p_luma_move) else $error("pixel data moved alone");
  property p_field_src; $changed(field_top_o) |-> since_evt != 4'hf; endproperty
  a_field_src: assert property (p_field_src) else $error("field moved without cause");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken early");
  property p_b_okay; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
  a_b_okay: assert property (p_b_okay) else $error("write not okay");
endmodule // video_front_end_props
bind video_front_end video_front_end_props #(.CNT_W(CNT_W)) i_props (
  .sys_clk_i, .arst_n_i, .double_rate_pixel_clock_i, .vsync_i, .field_indicator_input_i,
  .pix_valid_o, .pix_luma_o, .field_top_o, .s_axi_wvalid, .s_axi_wready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_bvalid, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* tb/video_front_end_tb_top.sv */
// self-checking bench for the video front end
`timescale 1ns/10ps
module video_front_end_tb_top;
  logic        sys_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  wire         double_rate_pixel_clock_i, pixel_clock_qualifier_i, hsync_i, vsync_i;
  wire         field_indicator_input_i, pix_valid_o, pix_top_field_o, field_top_o;
  wire  [7:0]  luma_bus_i, chroma_bus_i, pix_luma_o, pix_chroma_o;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          bad_count = 0;
  int          cmp_count = 0;
  logic [16:0] got_q[$];
  logic [16:0] exp_q[$];
  always #5 sys_clk_i = ~sys_clk_i;
  video_source_model i_src (.dclk_o(double_rate_pixel_clock_i), .qual_o(pixel_clock_qualifier_i),
    .luma_o(luma_bus_i), .chroma_o(chroma_bus_i), .hsync_o(hsync_i), .vsync_o(vsync_i),
    .field_o(field_indicator_input_i));
  video_front_end i_dut (.sys_clk_i, .arst_n_i, .double_rate_pixel_clock_i,
    .pixel_clock_qualifier_i, .luma_bus_i, .chroma_bus_i, .hsync_i, .vsync_i,
    .field_indicator_input_i, .pix_valid_o, .pix_luma_o, .pix_chroma_o, .pix_top_field_o,
    .field_top_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always @(posedge sys_clk_i) if (pix_valid_o === 1'b1)
    got_q.push_back({pix_top_field_o, pix_luma_o, pix_chroma_o});
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input [3:0] a, input [31:0] d);
    bit ad, dd;
    @(posedge sys_clk_i);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    ad = 0;
    dd = 0;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready) begin ad = 1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready) begin dd = 1; s_axi_wvalid <= 1'b0; end
    end while (!(ad && dd));
    do @(posedge sys_clk_i); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 2'h0);
  endtask
  task automatic rd(input [3:0] a, input [31:0] exp);
    @(posedge sys_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge sys_clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk_i); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, 2'h0);
  endtask
  // frames are 6 lines of 12 pixels; line 0 carries the vsync edge
  task automatic run_frame(input [5:0] c, input int vs, ve, hs, he, input bit wide, top);
    got_q.delete();
    exp_q.delete();
    wr(4'h0, {26'h0, c});
    wr(4'h4, {6'h0, ve[9:0], 6'h0, vs[9:0]});
    wr(4'h8, {6'h0, he[9:0], 6'h0, hs[9:0]});
    {i_src.qpol, i_src.vpol, i_src.hpol} = {c[5], c[3], c[2]};
    for (int j = 1; j < 6; j++)
      for (int k = 0; k < 12; k++)
        if (c[0] && j >= vs && j <= ve && k >= hs && k <= he)
          exp_q.push_back({top, k[7:0], j[7:0]});
    i_src.frame(6, 12, wide);
    repeat (20) @(posedge sys_clk_i);
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    chk(field_top_o, top);
  endtask
  task automatic t_regs();
    rd(4'h0, 32'h30);
    rd(4'h4, 32'h03ff0000);
    rd(4'h8, 32'h03ff0000);
    wr(4'h4, 32'hffffffff);
    rd(4'h4, 32'h03ff03ff);
    wr(4'hc, 32'h0);
    $display("regs done");
  endtask
  task automatic t_disabled();
    run_frame(6'h30, 1, 5, 2, 11, 1, 1);
    $display("disabled done");
  endtask
  task automatic t_window();
    run_frame(6'h31, 2, 4, 3, 7, 1, 1);
    $display("window done");
  endtask
  task automatic t_polarity();
    run_frame(6'h2d, 1, 1, 2, 2, 0, 0);
    run_frame(6'h2d, 5, 5, 11, 11, 0, 0);
    $display("polarity done");
  endtask
  task automatic t_ext_field();
    i_src.field_o = 1'b0;
    run_frame(6'h03, 3, 3, 4, 9, 0, 1);
    i_src.field_o = 1'b1;
    run_frame(6'h03, 3, 3, 4, 9, 1, 0);
    $display("external field done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_disabled();
    t_window();
    t_polarity();
    t_ext_field();
    finish_test();
  end
  // six frames of about 18 us each plus bus traffic; ample slack
  initial begin
    #300000;
    bad_count++;
    finish_test();
  end
endmodule // video_front_end_tb_top

/* tb/video_source_model.sv */
// behavioural digital video source on the double-rate pixel bus
`timescale 1ns/10ps
module video_source_model (
  // video pins
  output logic       dclk_o,
  output logic       qual_o,
  output logic [7:0] luma_o,
  output logic [7:0] chroma_o,
  output logic       hsync_o,
  output logic       vsync_o,
  output logic       field_o
);
  logic qpol = 1'b1;
  logic hpol = 1'b0;
  logic vpol = 1'b0;
  logic busy = 1'b0;
  initial {dclk_o, qual_o, luma_o, chroma_o, hsync_o, vsync_o, field_o} = '0;
  // a video source keeps its pixel clock running between frames
  always #62.5 dclk_o = ~dclk_o;
  always @(negedge dclk_o) if (!busy) begin
    qual_o <= ~qual_o;
    luma_o <= ~luma_o;
  end
  // luma carries the pixel index, chroma the line; off-edge halves are inverted junk
  task automatic frame(input int lines, input int pix, input bit wide);
    busy = 1'b1;
    for (int j = 0; j < lines; j++)
      for (int k = 0; k < pix; k++) begin
        @(negedge dclk_o);
        qual_o   = qpol;
        luma_o   = k[7:0];
        chroma_o = j[7:0];
        hsync_o  = (k < (wide ? 4 : 2)) ^ hpol;
        vsync_o  = ((j == 0 && k >= 2) || j == 1) ^ vpol;
        @(negedge dclk_o);
        qual_o   = ~qpol;
        luma_o   = ~luma_o;
        chroma_o = ~chroma_o;
      end
    hsync_o = hpol;
    vsync_o = vpol;
    busy    = 1'b0;
  endtask
endmodule // video_source_model
